// ---- logic/wwded_cfg.svh ----
// Address map, field positions, reset values and timing counts.
`ifndef WWDED_CFG_SVH
`define WWDED_CFG_SVH

// Byte addresses of the registers on the APB side.
`define WWDED_ADDR_CTRL 8'h00
`define WWDED_ADDR_STAT 8'h04
`define WWDED_ADDR_MASK 8'h08

// Field positions inside watchdog_control.
`define WWDED_B_RST_EARLY 30
`define WWDED_B_WIN_EN 29
`define WWDED_RST_VAL_HI 23
`define WWDED_RST_VAL_LO 20
`define WWDED_INT_VAL_HI 19
`define WWDED_INT_VAL_LO 16
`define WWDED_B_INT_EARLY 12
`define WWDED_B_RST_EN 11
`define WWDED_B_INT_EN 10
`define WWDED_B_EN 8

// Bit positions inside the status and mask registers.
`define WWDED_S_INT_EARLY 0
`define WWDED_S_RST_EARLY 1

// Reset values of the software-visible registers.
`define WWDED_CTRL_RST 32'h00000000
`define WWDED_EVT_RST 2'h0

// Threshold exponent for code zero, and the tick divider default.
`define WWDED_THR_TOP 5'h1f
`define WWDED_TICK_DIV 1

`endif

// ---- logic/wwded_pkg.sv ----
// Types shared by the windowed watchdog early-detect block.
`default_nettype none
package wwded_pkg;
  // Two-phase APB slave sequencer.
  typedef enum logic [0:0]
  {
    WWDED_IDLE = 1'b0,
    WWDED_ACC = 1'b1
  } wwded_apb_e;
  // Software-written control fields.
  typedef struct packed
  {
    logic win_en;
    logic rst_en;
    logic int_en;
    logic en;
    logic [3:0] rst_val;
    logic [3:0] int_val;
  } wwded_ctl_s;
  // Pair of early event flags, one bit each.
  typedef struct packed
  {
    logic rst_early;
    logic int_early;
  } wwded_evt_s;
endpackage
`default_nettype wire

// ---- logic/wwded_top.sv ----
// Early-feed detection of a windowed watchdog, with its APB registers.
`timescale 1ns/1ps
`default_nettype none
`include "wwded_cfg.svh"

module wwded_top #(
  parameter int TICK_DIV = `WWDED_TICK_DIV
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic FEED,
  output logic IRQ,
  output logic SYS_RST_REQ,
  output logic WDT_EN,
  output logic WIN_EN,
  output logic [31:0] COUNT
);

  // Bus sequencer state.
  wwded_pkg::wwded_apb_e state_r;
  // Control fields held by watchdog_control.
  wwded_pkg::wwded_ctl_s ctl_r;
  // Early flags held inside watchdog_control.
  wwded_pkg::wwded_evt_s flag_r;
  // Sticky status bits and their interrupt mask.
  wwded_pkg::wwded_evt_s stat_r;
  wwded_pkg::wwded_evt_s mask_r;
  // Events detected in this cycle.
  wwded_pkg::wwded_evt_s evt;
  // Watchdog counter, counted in watchdog ticks.
  logic [31:0] cnt_r;
  // Divider that makes the watchdog tick enable.
  logic [15:0] tick_cnt_r;
  logic tick;
  // Decoded thresholds in ticks.
  logic [31:0] thr_int;
  logic [31:0] thr_rst;
  // Bus decode and read data.
  logic hit;
  logic [31:0] rdata;
  logic wr_fire;
  logic feed_ok;
  // Registered outputs.
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic irq_r;
  logic rst_req_r;

  // Code n selects two to the power of 31 minus n ticks.
  function automatic logic [31:0] thr_of(input logic [3:0] code);
    logic [4:0] sh;
    sh = `WWDED_THR_TOP - {1'b0, code};
    thr_of = 32'h00000001 << sh;
  endfunction

  // Both thresholds decode from their four-bit codes.
  assign thr_int = thr_of(ctl_r.int_val);
  assign thr_rst = thr_of(ctl_r.rst_val);

  // A feed only counts while the watchdog runs; the feed
  // sequence itself is checked elsewhere in the unit.
  assign feed_ok = FEED & ctl_r.en;

  // Early events compare the count at the feed with each
  // threshold; the comparison ignores windowing on purpose.
  assign evt.int_early = feed_ok & (cnt_r < thr_int);
  assign evt.rst_early = feed_ok & (cnt_r < thr_rst);

  // A write takes effect only on the completing access edge.
  assign wr_fire = PSEL & PENABLE & pready_r & PWRITE;

  // Tick divider; with the default every clock is a tick.
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      tick_cnt_r <= 16'h0000;
    end
    else if (tick)
    begin
      tick_cnt_r <= 16'h0000;
    end
    else
    begin
      tick_cnt_r <= tick_cnt_r + 16'h0001;
    end
  end
  assign tick = (tick_cnt_r == 16'(TICK_DIV - 1));

  // The counter restarts on a feed, holds while disabled and
  // saturates rather than wrapping back into the early zone.
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      cnt_r <= 32'h00000000;
    end
    else if (feed_ok)
    begin
      cnt_r <= 32'h00000000;
    end
    else if (ctl_r.en && tick && cnt_r != 32'hffffffff)
    begin
      cnt_r <= cnt_r + 32'h00000001;
    end
  end

  // Control fields. Thresholds change at any time in hardware;
  // software is expected to stop the timer first, otherwise a
  // feed may be judged against a half-updated window.
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ctl_r <= wwded_pkg::wwded_ctl_s'(12'h000);
    end
    else if (wr_fire && PADDR == `WWDED_ADDR_CTRL)
    begin
      // Reserved bits are simply not stored.
      ctl_r.win_en <= PWDATA[`WWDED_B_WIN_EN];
      ctl_r.rst_en <= PWDATA[`WWDED_B_RST_EN];
      ctl_r.int_en <= PWDATA[`WWDED_B_INT_EN];
      ctl_r.en <= PWDATA[`WWDED_B_EN];
      ctl_r.rst_val <= PWDATA[`WWDED_RST_VAL_HI:`WWDED_RST_VAL_LO];
      ctl_r.int_val <= PWDATA[`WWDED_INT_VAL_HI:`WWDED_INT_VAL_LO];
    end
  end

  // Early flags are plain read/write bits; a hardware set in
  // the same cycle as a software write of zero wins.
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      flag_r <= `WWDED_EVT_RST;
    end
    else
    begin
      if (evt.int_early)
      begin
        flag_r.int_early <= 1'b1;
      end
      else if (wr_fire && PADDR == `WWDED_ADDR_CTRL)
      begin
        flag_r.int_early <= PWDATA[`WWDED_B_INT_EARLY];
      end
      if (evt.rst_early)
      begin
        flag_r.rst_early <= 1'b1;
      end
      else if (wr_fire && PADDR == `WWDED_ADDR_CTRL)
      begin
        flag_r.rst_early <= PWDATA[`WWDED_B_RST_EARLY];
      end
    end
  end

  // Status bits latch only events that windowing recognises;
  // writing one clears, and a new event beats the clear.
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      stat_r <= `WWDED_EVT_RST;
    end
    else if (wr_fire && PADDR == `WWDED_ADDR_STAT)
    begin
      stat_r <= (stat_r & ~PWDATA[1:0]) | (evt & {2{ctl_r.win_en}});
    end
    else
    begin
      stat_r <= stat_r | (evt & {2{ctl_r.win_en}});
    end
  end

  // Interrupt mask, same layout as the status register.
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      mask_r <= `WWDED_EVT_RST;
    end
    else if (wr_fire && PADDR == `WWDED_ADDR_MASK)
    begin
      mask_r <= PWDATA[1:0];
    end
  end

  // One level interrupt from the enabled early flag or any
  // unmasked status bit.
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      irq_r <= 1'b0;
    end
    else
    begin
      irq_r <= (flag_r.int_early & ctl_r.int_en) | (|(stat_r & mask_r));
    end
  end

  // System reset request is a one-cycle pulse; it needs both
  // windowing and the reset enable, the flag needs neither.
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rst_req_r <= 1'b0;
    end
    else
    begin
      rst_req_r <= evt.rst_early & ctl_r.win_en & ctl_r.rst_en;
    end
  end

  // Address decode and read data; unmapped reads return zero.
  always_comb
  begin
    hit = 1'b1;
    rdata = 32'h00000000;
    case (PADDR)
      `WWDED_ADDR_CTRL:
      begin
        rdata[`WWDED_B_RST_EARLY] = flag_r.rst_early;
        rdata[`WWDED_B_WIN_EN] = ctl_r.win_en;
        rdata[`WWDED_RST_VAL_HI:`WWDED_RST_VAL_LO] = ctl_r.rst_val;
        rdata[`WWDED_INT_VAL_HI:`WWDED_INT_VAL_LO] = ctl_r.int_val;
        rdata[`WWDED_B_INT_EARLY] = flag_r.int_early;
        rdata[`WWDED_B_RST_EN] = ctl_r.rst_en;
        rdata[`WWDED_B_INT_EN] = ctl_r.int_en;
        rdata[`WWDED_B_EN] = ctl_r.en;
      end
      `WWDED_ADDR_STAT:
      begin
        rdata[1:0] = stat_r;
      end
      `WWDED_ADDR_MASK:
      begin
        rdata[1:0] = mask_r;
      end
      default:
      begin
        hit = 1'b0;
      end
    endcase
  end

  // APB sequencer: the answer comes one cycle after setup,
  // with read data captured at that same edge.
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state_r <= wwded_pkg::WWDED_IDLE;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end
    else
    begin
      case (state_r)
        wwded_pkg::WWDED_IDLE:
        begin
          if (PSEL && !PENABLE)
          begin
            state_r <= wwded_pkg::WWDED_ACC;
            pready_r <= 1'b1;
            pslverr_r <= ~hit;
            prdata_r <= PWRITE ? 32'h00000000 : rdata;
          end
        end
        wwded_pkg::WWDED_ACC:
        begin
          // The access always ends here since ready was high.
          state_r <= wwded_pkg::WWDED_IDLE;
          pready_r <= 1'b0;
          pslverr_r <= 1'b0;
        end
        default:
        begin
          state_r <= wwded_pkg::WWDED_IDLE;
          pready_r <= 1'b0;
        end
      endcase
    end
  end

  // Outputs come straight from flip-flops.
  assign PRDATA = prdata_r;
  assign PREADY = pready_r;
  assign PSLVERR = pslverr_r;
  assign IRQ = irq_r;
  assign SYS_RST_REQ = rst_req_r;
  assign WDT_EN = ctl_r.en;
  assign WIN_EN = ctl_r.win_en;
  assign COUNT = cnt_r;

  // All checks below share the system clock and reset.
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_N);
  // A feed that lands before the interrupt threshold.
  sequence seq_early_int;
    FEED && ctl_r.en && (cnt_r < thr_int);
  endsequence
  // A feed that lands before the reset threshold.
  sequence seq_early_rst;
    FEED && ctl_r.en && (cnt_r < thr_rst);
  endsequence

  AST_INT_FLAG: assert property (seq_early_int |=> flag_r.int_early)
    else $error("Early feed did not set the interrupt flag.");
  AST_INT_NOWIN: assert property (
    (seq_early_int ##0 !ctl_r.win_en) |=> flag_r.int_early)
    else $error("Interrupt flag missed with windowing off.");
  AST_IRQ: assert property (
    (flag_r.int_early && ctl_r.int_en) |=> IRQ)
    else $error("Enabled early flag did not raise the interrupt.");
  AST_RST_GATE: assert property (
    SYS_RST_REQ |-> $past(ctl_r.rst_en) && $past(ctl_r.win_en))
    else $error("Reset request without reset and window enable.");
  AST_RSVD: assert property (
    (PREADY && !PWRITE && PADDR == `WWDED_ADDR_CTRL)
    |-> PRDATA[26:24] == 3'h0 && PRDATA[15:13] == 3'h0)
    else $error("Reserved control bits did not read as zero.");
  AST_RST_FLAG: assert property (seq_early_rst |=> flag_r.rst_early)
    else $error("Early reset event did not set its flag.");
  AST_NOWIN_STAT: assert property (
    !ctl_r.win_en && !wr_fire |=> stat_r == $past(stat_r))
    else $error("Status changed while windowing was off.");
  AST_HOLD: assert property (
    (!ctl_r.en && !FEED) |=> $stable(cnt_r))
    else $error("Counter moved while the watchdog was disabled.");
  AST_RST_REQ: assert property (
    (seq_early_rst ##0 ctl_r.win_en && ctl_r.rst_en)
    |=> SYS_RST_REQ ##1 !SYS_RST_REQ)
    else $error("Early reset did not give a one-cycle request.");
  AST_THR: assert property (
    ctl_r.rst_val == 4'hf |-> thr_rst == 32'h00010000)
    else $error("Shortest reset threshold is not two to the 16.");
  AST_THR_INT: assert property (
    ctl_r.int_val == 4'h0 |-> thr_int == 32'h80000000)
    else $error("Longest interrupt threshold is not two to the 31.");

endmodule
`default_nettype wire

// ---- test/wwded_top_test.sv ----
// Self-checking testbench for the windowed watchdog early-detect block.
`timescale 1ns/1ps
`default_nettype none
`include "wwded_cfg.svh"

module wwded_top_test;
  logic clk_sys = 1'b0; // System clock, 100 MHz.
  logic rst_n = 1'b0; // Active-low reset, held at start.
  logic psel = 1'b0; // APB select.
  logic penable = 1'b0; // APB access phase.
  logic pwrite = 1'b0; // APB direction.
  logic [7:0] paddr = 8'h00; // APB byte address.
  logic [31:0] pwdata = 32'h00000000; // APB write data.
  logic feed = 1'b0; // Completed feed sequence pulse.
  logic [31:0] prdata; // Read data from the block.
  logic pready; // Access-phase answer.
  logic pslverr; // Error answer for unmapped places.
  logic irq; // Interrupt level.
  logic sys_rst_req; // System reset request pulse.
  logic wdt_en; // Watchdog enable mirror.
  logic win_en; // Window enable mirror.
  logic [31:0] count; // Watchdog counter.
  int n_fail = 0; // Mismatches seen.
  int n_compared = 0; // Comparisons made.
  logic [31:0] cnt_a; // Counter snapshot.
  logic rst_seen; // A reset request was observed.

  wwded_top #(.TICK_DIV(1)) i_wwded_top (
    .CLK_SYS(clk_sys), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .FEED(feed), .IRQ(irq),
    .SYS_RST_REQ(sys_rst_req), .WDT_EN(wdt_en), .WIN_EN(win_en),
    .COUNT(count)
  );

  // Free-running clock, 10 ns period.
  always #5 clk_sys = ~clk_sys;

  // Prints the verdict and ends the run.
  task automatic give_verdict();
    if (n_fail == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One APB transfer; the wait for the answer is bounded.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    int i;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge clk_sys);
      if (pready === 1'b1)
        break;
    end
    // A missing answer counts as a failure and ends the run.
    if (i == 20)
    begin
      n_fail++;
      give_verdict();
    end
    else
    begin
      // Answer taken at the edge where ready was seen high.
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  // Register write that expects no error answer.
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
    chk("wr_err", 32'h0, {31'h0, err});
  endtask

  // Register read compared with an expected word.
  task automatic rd_reg(input string name, input logic [7:0] a,
                        input logic [31:0] exp);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0, rd, err);
    chk(name, exp, rd);
  endtask

  // Pulses the feed input for one cycle and watches for a reset request.
  task automatic do_feed();
    @(posedge clk_sys);
    feed <= 1'b1;
    @(posedge clk_sys);
    feed <= 1'b0;
    rst_seen = 1'b0;
    repeat (4)
    begin
      @(posedge clk_sys);
      if (sys_rst_req === 1'b1)
        rst_seen = 1'b1;
    end
  endtask

  // Reset values, reserved bits, the unmapped place and all codes.
  task automatic sc_regs();
    logic [31:0] rd;
    logic err;
    rd_reg("ctrl_rst", `WWDED_ADDR_CTRL, 32'h0);
    rd_reg("stat_rst", `WWDED_ADDR_STAT, 32'h0);
    rd_reg("mask_rst", `WWDED_ADDR_MASK, 32'h0);
    wr_reg(`WWDED_ADDR_CTRL, 32'hffffffff);
    rd_reg("ctrl_resv", `WWDED_ADDR_CTRL, 32'h60ff1d00);
    // Stop the timer first so the thresholds never change while it runs.
    wr_reg(`WWDED_ADDR_CTRL, 32'h60ff1c00);
    wr_reg(`WWDED_ADDR_CTRL, 32'h0);
    apb(1'b0, 8'h0c, 32'h0, rd, err);
    chk("unmap_err", 32'h1, {31'h0, err});
    chk("unmap_data", 32'h0, rd);
    // Both threshold fields take every code while the timer is stopped.
    for (int n = 0; n < 16; n++)
    begin
      wr_reg(`WWDED_ADDR_CTRL, {8'h0, n[3:0], 4'(15 - n), 16'h0});
      rd_reg("codes", `WWDED_ADDR_CTRL,
             {8'h0, n[3:0], 4'(15 - n), 16'h0});
    end
  endtask

  // Too-early feed with windowing off: flags and interrupt, no reset.
  task automatic sc_early_nowin();
    wr_reg(`WWDED_ADDR_CTRL, 32'h00ff0d00);
    do_feed();
    chk("rst_req_nowin", 32'h0, {31'h0, rst_seen});
    rd_reg("ctrl_flags", `WWDED_ADDR_CTRL, 32'h40ff1d00);
    chk("irq_on", 32'h1, {31'h0, irq});
    rd_reg("stat_nowin", `WWDED_ADDR_STAT, 32'h0);
    // Software clears the flags; the interrupt must drop.
    wr_reg(`WWDED_ADDR_CTRL, 32'h00ff0500);
    repeat (3) @(posedge clk_sys);
    chk("irq_off", 32'h0, {31'h0, irq});
  endtask

  // Counter runs while enabled and holds while disabled.
  task automatic sc_count();
    @(posedge clk_sys);
    cnt_a = count;
    repeat (10) @(posedge clk_sys);
    chk("count_run", cnt_a + 32'd10, count);
    wr_reg(`WWDED_ADDR_CTRL, 32'h00ff0000);
    @(posedge clk_sys);
    cnt_a = count;
    do_feed();
    repeat (6) @(posedge clk_sys);
    chk("count_hold", cnt_a, count);
    chk("wdt_en_off", 32'h0, {31'h0, wdt_en});
    rd_reg("feed_off", `WWDED_ADDR_CTRL, 32'h00ff0000);
  endtask

  // Windowing on: reset request only with its enable, status and mask.
  task automatic sc_window();
    wr_reg(`WWDED_ADDR_CTRL, 32'h20ff0900);
    do_feed();
    chk("rst_req_on", 32'h1, {31'h0, rst_seen});
    // The feed restarted the count; three ticks have passed since.
    chk("count_feed", 32'h3, count);
    chk("wdt_en_on", 32'h1, {31'h0, wdt_en});
    chk("win_en_on", 32'h1, {31'h0, win_en});
    rd_reg("stat_win", `WWDED_ADDR_STAT, 32'h3);
    wr_reg(`WWDED_ADDR_CTRL, 32'h20ff0000);
    wr_reg(`WWDED_ADDR_STAT, 32'h3);
    wr_reg(`WWDED_ADDR_CTRL, 32'h20ff0100);
    do_feed();
    chk("rst_req_off", 32'h0, {31'h0, rst_seen});
    wr_reg(`WWDED_ADDR_CTRL, 32'h20ff0000);
    repeat (3) @(posedge clk_sys);
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr_reg(`WWDED_ADDR_MASK, 32'h1);
    repeat (3) @(posedge clk_sys);
    chk("irq_unmasked", 32'h1, {31'h0, irq});
    wr_reg(`WWDED_ADDR_STAT, 32'h1);
    rd_reg("stat_w1c", `WWDED_ADDR_STAT, 32'h2);
    chk("irq_cleared", 32'h0, {31'h0, irq});
  endtask

  // Main sequence: reset for three cycles, then every scenario.
  initial
  begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    sc_regs();
    sc_early_nowin();
    sc_count();
    sc_window();
    give_verdict();
  end

  // Cuts a hang short well inside the cycle budget.
  initial
  begin
    repeat (50000) @(posedge clk_sys);
    n_fail++;
    give_verdict();
  end
endmodule
`default_nettype wire
